// ---- swr_pkg.sv ----
// Package for the sleep, wakeup and reset sequencer: offsets, fields, timing
package swr_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses of the CPU space)
  // ------------------------------------------------------------------
  localparam logic [15:0] CPU_FLAGS_STATUS_ADDR   = 16'hc000;
  localparam logic [15:0] REGISTER_BANK_BASE_ADDR = 16'hc002;
  localparam logic [15:0] SILICON_REVISION_ADDR   = 16'hc004;
  localparam logic [15:0] CPU_CLOCK_DIVISOR_ADDR  = 16'hc008;
  localparam logic [15:0] POWER_WAKE_CONTROL_ADDR = 16'hc00a;
  localparam logic [15:0] INTERRUPT_ENABLES_ADDR  = 16'hc00e;
  localparam logic [15:0] BREAKPOINT_ADDRESS_ADDR = 16'hc014;
  localparam logic [15:0] USB_DIAGNOSTIC_ADDR     = 16'hc03c;
  localparam logic [15:0] MEMORY_DIAGNOSTIC_ADDR  = 16'hc03e;
  localparam logic [15:0] USB_RESET_REG_A_ADDR    = 16'hc090;
  localparam logic [15:0] USB_RESET_REG_B_ADDR    = 16'hc0b0;

  // ------------------------------------------------------------------
  // Memory map
  // ------------------------------------------------------------------
  localparam logic [15:0] CTRL_REG_LO   = 16'hc000;
  localparam logic [15:0] CTRL_REG_HI   = 16'hc0ff;
  localparam logic [15:0] BOOT_ROM_LO   = 16'he000;
  localparam logic [15:0] BOOT_ROM_HI   = 16'hffff;
  localparam logic [15:0] EXT_RAM_LO    = 16'h4000;
  localparam logic [15:0] EXT_RAM_HI    = 16'hbfff;
  localparam logic [15:0] EXT_ROM_LO    = 16'hc100;
  localparam logic [15:0] EXT_ROM_HI    = 16'hdfff;
  localparam logic [15:0] RESET_VECTOR  = 16'hff00;
  localparam logic [15:0] BOOT_ENTRY    = 16'he000;

  // ------------------------------------------------------------------
  // Power control fields
  // ------------------------------------------------------------------
  localparam int HALT_EN_BIT     = 0;
  localparam int SLEEP_EN_BIT    = 1;
  localparam int BOOST_OK_BIT    = 2;
  localparam int GPI_WAKE_BIT    = 4;
  localparam int HPI_WAKE_BIT    = 7;
  localparam int SPI_WAKE_BIT    = 8;
  localparam int HSS_WAKE_BIT    = 9;
  localparam int OTG_WAKE_BIT    = 11;
  localparam int USB_WAKE_LO_BIT = 12;
  localparam logic [15:0] POWER_WRITE_MASK = 16'hfb93;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] BANK_RESET     = 16'h0100;
  localparam logic [15:0] BANK_MASK      = 16'hffe0;
  localparam logic [3:0]  DIVISOR_RESET  = 4'hf;
  localparam logic [15:0] POWER_RESET    = 16'h0000;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  // Arbitrary neutral identity value
  localparam logic [15:0] REVISION_VALUE = 16'h0001;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLOCK_MHZ       = 100;
  localparam int PLL_SETTLE_US   = 200;
  localparam int PLL_SETTLE_CYC  = PLL_SETTLE_US * CLOCK_MHZ;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic zero;
    logic carry;
    logic overflow;
    logic negative;
    logic global_irq;
  } swr_flags_t;

  typedef struct packed {
    logic usb_resume;
    logic bus_power;
    logic otg_id;
    logic irq_zero;
    logic irq_one;
    logic host_read;
    logic serial_read;
    logic spi_read;
  } swr_wake_t;

  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_SLEEP, ST_SETTLE} swr_state_t;

  typedef struct packed {
    swr_state_t  state;
    logic [31:0] settle_cnt;
    logic [15:0] bank;
    logic [3:0]  divisor;
    logic [15:0] power;
    logic [15:0] irq_en;
    logic [15:0] brk;
    logic [15:0] usb_diag;
    logic [15:0] mem_diag;
    logic [15:0] usb_reg_a;
    logic [15:0] usb_reg_b;
    logic [3:0]  div_cnt;
    logic        cpu_ce;
    logic [15:0] rdata;
    logic        dummy;
    logic [2:0]  edge_prev;
    logic [15:0] ext_addr;
    logic        ram_sel_n;
    logic        rom_sel_n;
    logic        host_int;
    logic        fetch_valid;
    logic [15:0] fetch_addr;
  } swr_state_reg_t;

endpackage

// ---- swr_sleep_wake_reset_control.sv ----
// Sleep entry, wakeup, reset sequencing, CPU divider and address decode
//
// Summary of operation
// - Writing sleep enable bit enters sleep
// - General pins keep configuration while asleep
// - External address outputs low while asleep
// - Crystal drive and PLL off asleep
// - Supply booster disabled while asleep
// - USB transceivers powered down while asleep
// - CPU suspended until programmed wakeup event
// - Resume, bus power, ID, IRQ edges wake
// - Port reads wake; returned data is dummy
// - USB resume raises host port interrupt
// - Code resumes after PLL settle interval
// - Reset pin restores all register defaults
// - Fetch starts at reset vector, jumps boot
// - USB reset touches only two registers
// - CPU divisor slows CPU clock only
// - Decode control registers and boot ROM
// - External selects idle for internal accesses
// - RAM and ROM select address windows
// - Flags read-only; bit four global enable
// - Bit three negative flag from result
// - Bit two overflow flag
// - Bit one carry or borrow flag
// - Bit zero zero-result flag
`timescale 1ns/1ps
`default_nettype none

module swr_sleep_wake_reset_control #(
  parameter int SETTLE_CYCLES = swr_pkg::PLL_SETTLE_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  // CPU register and memory access port
  input  wire logic              cpu_req_in,
  input  wire logic              cpu_write_in,
  input  wire logic [15:0]       cpu_addr_in,
  input  wire logic [15:0]       cpu_wdata_in,
  output logic      [15:0]       cpu_rdata_out,
  output logic                   ctrl_reg_hit_out,
  output logic                   boot_rom_hit_out,
  input  wire logic              ram_merge_en_in,
  input  wire swr_pkg::swr_flags_t cpu_flags_in,
  input  wire logic              usb_bus_reset_in,
  // Wake sources from pins and ports
  input  wire logic              usb_resume_in,
  input  wire logic              otg_bus_power_sense_in,
  input  wire logic              otg_role_id_input_in,
  input  wire logic              external_irq_zero_in,
  input  wire logic              external_irq_one_in,
  input  wire logic              parallel_host_port_read_in,
  input  wire logic              fast_serial_port_read_in,
  input  wire logic              spi_read_in,
  input  wire logic              boost_ok_in,
  // Power and sequencing outputs
  output logic                   dummy_read_data_out,
  output logic                   host_port_interrupt_out,
  output logic                   crystal_drive_output_en_out,
  output logic                   pll_enable_out,
  output logic                   booster_enable_out,
  output logic                   usb_xcvr_enable_out,
  output logic                   gpio_hold_out,
  output logic                   cpu_run_out,
  output logic                   cpu_clock_en_out,
  output logic                   fetch_valid_out,
  output logic      [15:0]       fetch_addr_out,
  output logic      [15:0]       ext_addr_out,
  output logic                   ext_ram_select_n_out,
  output logic                   ext_rom_select_n_out
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] pins_raw;

  assign pins_raw = {usb_resume_in, otg_bus_power_sense_in, otg_role_id_input_in,
                     external_irq_zero_in, external_irq_one_in,
                     parallel_host_port_read_in, fast_serial_port_read_in, spi_read_in};

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en_in) begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  swr_pkg::swr_wake_t wake;
  assign wake = swr_pkg::swr_wake_t'(sync2_reg);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] flags_word(input swr_pkg::swr_flags_t f);
    flags_word = {11'h000, f.global_irq, f.negative, f.overflow, f.carry, f.zero};
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  swr_pkg::swr_state_reg_t s_reg;
  swr_pkg::swr_state_reg_t s_next;

  logic       asleep;
  logic       awake_cpu;
  logic       wake_hit;
  logic       port_read_wake;
  logic       wr;
  logic       rd;
  logic       ext_ram;
  logic       ext_rom;
  logic [2:0] edge_now;

  assign asleep    = (s_reg.state == swr_pkg::ST_SLEEP);
  assign awake_cpu = (s_reg.state == swr_pkg::ST_RUN);
  assign wr        = cpu_req_in && cpu_write_in && awake_cpu;
  assign rd        = cpu_req_in && !cpu_write_in && awake_cpu;
  assign edge_now  = {wake.otg_id, wake.irq_zero, wake.irq_one};

  // Read-type port accesses count as wake events when their enable is set
  assign port_read_wake =
      (wake.host_read   && s_reg.power[swr_pkg::HPI_WAKE_BIT]) ||
      (wake.serial_read && s_reg.power[swr_pkg::HSS_WAKE_BIT]) ||
      (wake.spi_read    && s_reg.power[swr_pkg::SPI_WAKE_BIT]);

  assign wake_hit =
      (wake.usb_resume && (|s_reg.power[15:swr_pkg::USB_WAKE_LO_BIT])) ||
      (wake.bus_power  && s_reg.power[swr_pkg::OTG_WAKE_BIT]) ||
      ((wake.otg_id != s_reg.edge_prev[2]) && s_reg.power[swr_pkg::OTG_WAKE_BIT]) ||
      ((edge_now[1:0] != s_reg.edge_prev[1:0]) && s_reg.power[swr_pkg::GPI_WAKE_BIT]) ||
      port_read_wake;

  // Decode of the CPU address space
  assign ext_ram = in_range(cpu_addr_in, swr_pkg::EXT_RAM_LO, swr_pkg::EXT_RAM_HI)
                   && ram_merge_en_in;
  assign ext_rom = in_range(cpu_addr_in, swr_pkg::EXT_ROM_LO, swr_pkg::EXT_ROM_HI);

  always_comb begin
    s_next = s_reg;
    s_next.edge_prev = edge_now;
    s_next.host_int  = 1'b0;
    s_next.dummy     = 1'b0;
    s_next.fetch_valid = 1'b0;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    unique case (s_reg.state)
      swr_pkg::ST_BOOT: begin
        // Wait after reset release before the first fetch
        if (s_reg.settle_cnt >= 32'(SETTLE_CYCLES - 1)) begin
          s_next.state       = swr_pkg::ST_RUN;
          s_next.settle_cnt  = '0;
          s_next.fetch_valid = 1'b1;
          s_next.fetch_addr  = swr_pkg::RESET_VECTOR;
        end else begin
          s_next.settle_cnt = s_reg.settle_cnt + 32'd1;
        end
      end
      swr_pkg::ST_RUN: begin
        if (s_reg.fetch_addr == swr_pkg::RESET_VECTOR &&
            s_reg.settle_cnt == '0) begin
          // Immediate jump from the reset vector into the boot ROM
          s_next.fetch_valid = 1'b1;
          s_next.fetch_addr  = swr_pkg::BOOT_ENTRY;
          s_next.settle_cnt  = 32'd1;
        end
        if (wr && cpu_addr_in == swr_pkg::POWER_WAKE_CONTROL_ADDR &&
            cpu_wdata_in[swr_pkg::SLEEP_EN_BIT]) begin
          s_next.state = swr_pkg::ST_SLEEP;
        end
      end
      swr_pkg::ST_SLEEP: begin
        // CPU stays suspended; disabled sources are simply not looked at
        if (wake_hit) begin
          s_next.state      = swr_pkg::ST_SETTLE;
          s_next.settle_cnt = '0;
          if (wake.usb_resume && (|s_reg.power[15:swr_pkg::USB_WAKE_LO_BIT])) begin
            s_next.host_int = 1'b1;
          end
          if (port_read_wake) begin
            s_next.dummy = 1'b1;
          end
        end
      end
      swr_pkg::ST_SETTLE: begin
        // Circuits already restarted; release only once the PLL has settled
        if (s_reg.settle_cnt >= 32'(SETTLE_CYCLES - 1)) begin
          s_next.state = swr_pkg::ST_RUN;
          s_next.power[swr_pkg::SLEEP_EN_BIT] = 1'b0;
        end else begin
          s_next.settle_cnt = s_reg.settle_cnt + 32'd1;
        end
      end
    endcase

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (wr) begin
      unique case (cpu_addr_in)
        swr_pkg::REGISTER_BANK_BASE_ADDR: s_next.bank = cpu_wdata_in & swr_pkg::BANK_MASK;
        swr_pkg::CPU_CLOCK_DIVISOR_ADDR:  s_next.divisor = cpu_wdata_in[3:0];
        swr_pkg::POWER_WAKE_CONTROL_ADDR: s_next.power =
            cpu_wdata_in & swr_pkg::POWER_WRITE_MASK;
        swr_pkg::INTERRUPT_ENABLES_ADDR:  s_next.irq_en = cpu_wdata_in;
        swr_pkg::BREAKPOINT_ADDRESS_ADDR: s_next.brk = cpu_wdata_in;
        swr_pkg::USB_DIAGNOSTIC_ADDR:     s_next.usb_diag = cpu_wdata_in;
        swr_pkg::MEMORY_DIAGNOSTIC_ADDR:  s_next.mem_diag = cpu_wdata_in;
        swr_pkg::USB_RESET_REG_A_ADDR:    s_next.usb_reg_a = cpu_wdata_in;
        swr_pkg::USB_RESET_REG_B_ADDR:    s_next.usb_reg_b = cpu_wdata_in;
        default: ;
      endcase
    end

    // USB bus reset clears only these two registers
    if (usb_bus_reset_in) begin
      s_next.usb_reg_a = swr_pkg::ZERO_WORD;
      s_next.usb_reg_b = swr_pkg::ZERO_WORD;
    end

    // --------------------------------------------------------------
    // Register reads; flags register has no write path
    // --------------------------------------------------------------
    if (rd) begin
      unique case (cpu_addr_in)
        swr_pkg::CPU_FLAGS_STATUS_ADDR:   s_next.rdata = flags_word(cpu_flags_in);
        swr_pkg::REGISTER_BANK_BASE_ADDR: s_next.rdata = s_reg.bank;
        swr_pkg::SILICON_REVISION_ADDR:   s_next.rdata = swr_pkg::REVISION_VALUE;
        swr_pkg::CPU_CLOCK_DIVISOR_ADDR:  s_next.rdata = {12'h000, s_reg.divisor};
        swr_pkg::POWER_WAKE_CONTROL_ADDR: begin
          s_next.rdata = s_reg.power;
          s_next.rdata[swr_pkg::BOOST_OK_BIT] = boost_ok_in;
        end
        swr_pkg::INTERRUPT_ENABLES_ADDR:  s_next.rdata = s_reg.irq_en;
        swr_pkg::BREAKPOINT_ADDRESS_ADDR: s_next.rdata = s_reg.brk;
        swr_pkg::USB_RESET_REG_A_ADDR:    s_next.rdata = s_reg.usb_reg_a;
        swr_pkg::USB_RESET_REG_B_ADDR:    s_next.rdata = s_reg.usb_reg_b;
        default:                          s_next.rdata = swr_pkg::ZERO_WORD;
      endcase
    end

    // --------------------------------------------------------------
    // CPU clock enable: one pulse every divisor+1 system cycles
    // --------------------------------------------------------------
    if (awake_cpu) begin
      if (s_reg.div_cnt >= s_reg.divisor) begin
        s_next.div_cnt = 4'h0;
        s_next.cpu_ce  = 1'b1;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 4'h1;
        s_next.cpu_ce  = 1'b0;
      end
    end else begin
      s_next.div_cnt = 4'h0;
      s_next.cpu_ce  = 1'b0;
    end

    // --------------------------------------------------------------
    // External memory interface
    // --------------------------------------------------------------
    if (s_next.state == swr_pkg::ST_SLEEP) begin
      s_next.ext_addr  = swr_pkg::ZERO_WORD;
      s_next.ram_sel_n = 1'b1;
      s_next.rom_sel_n = 1'b1;
    end else if (cpu_req_in && awake_cpu) begin
      s_next.ext_addr  = cpu_addr_in;
      s_next.ram_sel_n = !ext_ram;
      s_next.rom_sel_n = !ext_rom;
    end else begin
      s_next.ram_sel_n = 1'b1;
      s_next.rom_sel_n = 1'b1;
    end
  end

  // Reset pin event returns every register to its default
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg.state       <= swr_pkg::ST_BOOT;
      s_reg.settle_cnt  <= '0;
      s_reg.bank        <= swr_pkg::BANK_RESET;
      s_reg.divisor     <= swr_pkg::DIVISOR_RESET;
      s_reg.power       <= swr_pkg::POWER_RESET;
      s_reg.irq_en      <= swr_pkg::ZERO_WORD;
      s_reg.brk         <= swr_pkg::ZERO_WORD;
      s_reg.usb_diag    <= swr_pkg::ZERO_WORD;
      s_reg.mem_diag    <= swr_pkg::ZERO_WORD;
      s_reg.usb_reg_a   <= swr_pkg::ZERO_WORD;
      s_reg.usb_reg_b   <= swr_pkg::ZERO_WORD;
      s_reg.div_cnt     <= 4'h0;
      s_reg.cpu_ce      <= 1'b0;
      s_reg.rdata       <= swr_pkg::ZERO_WORD;
      s_reg.dummy       <= 1'b0;
      s_reg.edge_prev   <= 3'h0;
      s_reg.ext_addr    <= swr_pkg::ZERO_WORD;
      s_reg.ram_sel_n   <= 1'b1;
      s_reg.rom_sel_n   <= 1'b1;
      s_reg.host_int    <= 1'b0;
      s_reg.fetch_valid <= 1'b0;
      s_reg.fetch_addr  <= swr_pkg::ZERO_WORD;
    end else if (clk_en_in) begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cpu_rdata_out           = s_reg.rdata;
  assign dummy_read_data_out     = s_reg.dummy;
  assign host_port_interrupt_out = s_reg.host_int;
  // Sleep gates the clock sources, booster and transceivers off
  assign crystal_drive_output_en_out = !asleep;
  assign pll_enable_out          = !asleep;
  assign booster_enable_out      = !asleep;
  assign usb_xcvr_enable_out     = !asleep;
  // GPIO block freezes its direction and configuration while this is high
  assign gpio_hold_out           = asleep;
  assign cpu_run_out             = awake_cpu;
  assign cpu_clock_en_out        = s_reg.cpu_ce;
  assign fetch_valid_out         = s_reg.fetch_valid;
  assign fetch_addr_out          = s_reg.fetch_addr;
  assign ext_addr_out            = s_reg.ext_addr;
  assign ext_ram_select_n_out    = s_reg.ram_sel_n;
  assign ext_rom_select_n_out    = s_reg.rom_sel_n;
  assign ctrl_reg_hit_out = in_range(cpu_addr_in, swr_pkg::CTRL_REG_LO, swr_pkg::CTRL_REG_HI);
  assign boot_rom_hit_out = in_range(cpu_addr_in, swr_pkg::BOOT_ROM_LO, swr_pkg::BOOT_ROM_HI);

endmodule

`default_nettype wire

// ---- swr_asserts.sv ----
// Checker for sleep entry, sleep states, wake timing, boot vector and selects
`timescale 1ns/1ps
`default_nettype none
module swr_asserts #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic        clock_in, rst_b_in, clk_en_in, cpu_req_in, cpu_write_in,
  input wire logic [15:0] cpu_addr_in, cpu_wdata_in, fetch_addr_out, ext_addr_out,
  input wire logic        ram_merge_en_in, host_port_interrupt_out, gpio_hold_out,
  input wire logic        crystal_drive_output_en_out, pll_enable_out, booster_enable_out,
  input wire logic        usb_xcvr_enable_out, cpu_run_out, fetch_valid_out,
  input wire logic        ext_ram_select_n_out, ext_rom_select_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic        acc;
  logic [31:0] wait_reg;
  assign acc = clk_en_in && cpu_req_in && cpu_run_out;
  // Cycles spent awake but not yet released to the CPU
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) wait_reg <= 32'h0;
    else if (cpu_run_out || gpio_hold_out) wait_reg <= 32'h0;
    else wait_reg <= wait_reg + 32'h1;
  end
  sequence s_sleep_wr; acc && cpu_write_in && cpu_addr_in == 16'hc00a && cpu_wdata_in[1]; endsequence
  sequence s_woke; $fell(gpio_hold_out); endsequence
  property p_enter; s_sleep_wr |=> gpio_hold_out; endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered");
  property p_osc; gpio_hold_out |-> !crystal_drive_output_en_out && !pll_enable_out; endproperty
  a_osc: assert property (p_osc) else $error("clock running asleep");
  property p_power; gpio_hold_out |-> !booster_enable_out && !usb_xcvr_enable_out; endproperty
  a_power: assert property (p_power) else $error("booster or transceiver on asleep");
  property p_addr; gpio_hold_out |-> ext_addr_out == 16'h0000 && !cpu_run_out; endproperty
  a_addr: assert property (p_addr) else $error("address or cpu active asleep");
  property p_hold; s_woke |-> !cpu_run_out [*8]; endproperty
  a_hold: assert property (p_hold) else $error("cpu released early");
  property p_release; $rose(cpu_run_out) |-> wait_reg >= SETTLE_CYCLES - 1; endproperty
  a_release: assert property (p_release) else $error("settle too short");
  property p_bound; wait_reg <= SETTLE_CYCLES + 6; endproperty
  a_bound: assert property (p_bound) else $error("settle too long");
  property p_boot; fetch_valid_out && fetch_addr_out == 16'hff00
    |=> fetch_valid_out && fetch_addr_out == 16'he000; endproperty
  a_boot: assert property (p_boot) else $error("boot jump missing");
  property p_hint; host_port_interrupt_out |-> !cpu_run_out ##1 !host_port_interrupt_out; endproperty
  a_hint: assert property (p_hint) else $error("host interrupt misplaced");
  property p_int; acc && cpu_addr_in inside {[16'hc000:16'hc0ff]}
    |=> ext_ram_select_n_out && ext_rom_select_n_out; endproperty
  a_int: assert property (p_int) else $error("select on internal access");
  property p_rom; acc && cpu_addr_in inside {[16'hc100:16'hdfff]} |=> !ext_rom_select_n_out; endproperty
  a_rom: assert property (p_rom) else $error("rom select missing");
  property p_ram; acc && ram_merge_en_in && cpu_addr_in inside {[16'h4000:16'hbfff]}
    |=> !ext_ram_select_n_out; endproperty
  a_ram: assert property (p_ram) else $error("ram select missing");
endmodule
bind swr_sleep_wake_reset_control swr_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- swr_partner.sv ----
// Far side: wake pins, host port and serial reads, one source at a time
`timescale 1ns/1ps
`default_nettype none
module swr_partner (
  input  wire logic              clock_in,
  input  wire logic              fire_in,
  input  wire logic [2:0]        src_in,
  output var swr_pkg::swr_wake_t wake_out
);
  logic [3:0] hold_reg = 4'h0;
  // Held 15 cycles so the two-flop synchroniser cannot miss it, then released
  always_ff @(posedge clock_in) begin
    if (fire_in) hold_reg <= 4'hf;
    else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
  end
  always_comb begin
    wake_out = '0;
    if (hold_reg != 4'h0) wake_out[3'd7 - src_in] = 1'b1;
  end
endmodule
`default_nettype wire

// ---- swr_sleep_wake_reset_control_tb_top.sv ----
// Self-checking bench for the sleep, wakeup and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module swr_sleep_wake_reset_control_tb_top;
  logic clock_in, rst_b = 1'b0, req = 1'b0, wr = 1'b0, merge = 1'b0, fire = 1'b0, ubr = 1'b0;
  logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, fa;
  logic [2:0] src = 3'h0;
  logic hint, dumm, hold, run, fv, ramn, romn, cke, chit, bhit;
  swr_pkg::swr_flags_t flags = '0;
  swr_pkg::swr_wake_t wk;
  int n_fail = 0, comparisons = 0, hi_n = 0, dm_n = 0, ck_n = 0;
  int eb [8] = '{12, 11, 11, 4, 4, 7, 9, 8};
  logic [15:0] sa [7] = '{16'h4000, 16'hbfff, 16'h4000, 16'hc100, 16'hdfff, 16'hc0ff, 16'he000};
  logic [2:0] se [7] = '{3'b101, 3'b101, 3'b011, 3'b110, 3'b010, 3'b111, 3'b111};
  swr_sleep_wake_reset_control #(.SETTLE_CYCLES(20)) i_dut (.clock_in(clock_in),
    .rst_b_in(rst_b), .clk_en_in(1'b1), .cpu_req_in(req), .cpu_write_in(wr),
    .cpu_addr_in(addr), .cpu_wdata_in(wdata), .cpu_rdata_out(rdata), .ctrl_reg_hit_out(chit),
    .boot_rom_hit_out(bhit), .ram_merge_en_in(merge), .cpu_flags_in(flags),
    .usb_bus_reset_in(ubr), .usb_resume_in(wk.usb_resume), .otg_bus_power_sense_in(wk.bus_power),
    .otg_role_id_input_in(wk.otg_id), .external_irq_zero_in(wk.irq_zero),
    .external_irq_one_in(wk.irq_one), .parallel_host_port_read_in(wk.host_read),
    .fast_serial_port_read_in(wk.serial_read), .spi_read_in(wk.spi_read), .boost_ok_in(1'b0),
    .dummy_read_data_out(dumm), .host_port_interrupt_out(hint),
    .crystal_drive_output_en_out(), .pll_enable_out(), .booster_enable_out(),
    .usb_xcvr_enable_out(), .gpio_hold_out(hold), .cpu_run_out(run), .cpu_clock_en_out(cke),
    .fetch_valid_out(fv), .fetch_addr_out(fa), .ext_addr_out(), .ext_ram_select_n_out(ramn),
    .ext_rom_select_n_out(romn));
  swr_partner i_far (.clock_in(clock_in), .fire_in(fire), .src_in(src), .wake_out(wk));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (hint === 1'b1) hi_n++;
    if (dumm === 1'b1) dm_n++;
    if (cke === 1'b1) ck_n++;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_in);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    req <= 1'b0;
    #1;
  endtask
  task pulse(input int s);
    @(posedge clock_in);
    src <= 3'(s);
    fire <= 1'b1;
    @(posedge clock_in);
    fire <= 1'b0;
  endtask
  task t_boot;
    int t;
    t = 0;
    while (fv !== 1'b1 && t < 100) begin
      @(posedge clock_in);
      #1;
      t++;
    end
    chk("vector", 16'hff00, fa);
    chk("boot wait", 16'h0001, {15'h0, t >= 20});
    @(posedge clock_in);
    #1;
    chk("boot entry", 16'he000, fa);
    @(posedge clock_in);
    #1;
    chk("run", 16'h0001, {15'h0, run});
  endtask
  task t_regs;
    int c0;
    bus(0, 16'hc002, 16'h0);
    chk("bank", 16'h0100, rdata);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_in);
      flags <= i ? 5'b01001 : 5'b10110;
      bus(1, 16'hc000, 16'hffff);
      bus(0, 16'hc000, 16'h0);
      chk("flags", i ? 16'h0012 : 16'h000d, rdata);
    end
    bus(0, 16'hc0f0, 16'h0);
    chk("unmapped", 16'h0000, rdata);
    bus(1, 16'hc090, 16'h1234);
    bus(1, 16'hc00e, 16'h5a5a);
    bus(0, 16'hc090, 16'h0);
    chk("usb reg", 16'h1234, rdata);
    @(posedge clock_in);
    ubr <= 1'b1;
    @(posedge clock_in);
    ubr <= 1'b0;
    bus(0, 16'hc090, 16'h0);
    chk("usb reset reg", 16'h0000, rdata);
    bus(0, 16'hc00e, 16'h0);
    chk("irq enables", 16'h5a5a, rdata);
    foreach (sa[i]) begin
      @(posedge clock_in);
      merge <= se[i][2];
      bus(0, sa[i], 16'h0);
      chk("selects", {14'h0, se[i][1:0]}, {14'h0, ramn, romn});
      chk("hits", {14'h0, sa[i][15:8] == 8'hc0, &sa[i][15:13]}, {14'h0, chit, bhit});
    end
    bus(1, 16'hc008, 16'h0003);
    c0 = ck_n;
    repeat (16) @(posedge clock_in);
    #1;
    chk("cpu ticks", 16'd4, 16'(ck_n - c0));
  endtask
  task t_wake(input int s);
    int t, h, d;
    h = hi_n;
    d = dm_n;
    t = 0;
    bus(1, 16'hc098, 16'h0000);
    bus(1, 16'hc00a, 16'h0002 | (16'h0001 << eb[s]));
    chk("asleep", 16'h0001, {15'h0, hold});
    if (s == 3) begin
      pulse(0);
      repeat (40) @(posedge clock_in);
      chk("ignored", 16'h0001, {15'h0, hold});
    end
    pulse(s);
    while (run !== 1'b1 && t < 300) begin
      @(posedge clock_in);
      t++;
    end
    chk("settle", 16'h0001, {15'h0, t >= 20 && t < 300});
    chk("host int", 16'(s == 0), 16'(hi_n - h));
    chk("dummy", 16'(s >= 5), 16'(dm_n - d));
  endtask
  task summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    int c;
    repeat (8) @(posedge clock_in);
    rst_b <= 1'b1;
    t_boot;
    t_regs;
    c = ck_n;
    repeat (40) @(posedge clock_in);
    #1;
    chk("cpu ticks", 16'd10, 16'(ck_n - c));
    foreach (eb[i]) t_wake(i);
    bus(1, 16'hc00a, 16'h0010);
    @(posedge clock_in);
    rst_b <= 1'b0;
    repeat (140) @(posedge clock_in);
    rst_b <= 1'b1;
    t_boot;
    bus(0, 16'hc00a, 16'h0);
    chk("power", 16'h0000, rdata);
    bus(0, 16'hc008, 16'h0);
    chk("divisor", 16'h000f, rdata);
    summarize;
  end
  // Whole run is well under a thousand cycles; this cuts a hang at 10000
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
endmodule
`default_nettype wire
